// ---- include/cwp_map.vh ----
// Function
// RL1: Read-only byte reports security level: 00 open, 01 public, 02 user, 03 vendor.
// RL2: Reads of every command are always answered; protection gates writes only.
// RL3: Writes to non-writable commands are refused until a fitting password arrives.
// RL4: Two password classes exist, public and private; public guards accidental changes; the code gates no write on level 1.
// RL5: Host sends the public password before making configuration changes.
// RL6: Correct private password unlocks commands marked non-writable in the mask.
// RL7: User and default stores each keep their own mask and private password.
// RL8: Command cleared in default mask unlocks only with the default private password.
// RL9: Command allowed by default mask but blocked by user mask unlocks with user password.
// RL10: User private password is a 9-byte readable and writable block, bits 71:0.
// RL11: Password strings use the same byte-string layout as identification text.
// RL12: Public password arrives as a 4-byte block, bits 31:0.
// RL13: Protection mask is 256 bits, moved as a 32-byte readable and writable block.
// RL14: Mask bit n of the ascending byte array guards command code n.
// RL15: Every code owns a mask bit, supported or not.
// RL16: Cleared mask bit allows writes only once the level is high enough.
// RL17: Default-store mask is writable only at level 3 or above.
// RL18: User-store mask is writable only at level 2 or above.
// RL19: Public password gives level 1, user private 2, default private 3.
// RL20: Wrong password keeps the level; writes to protected commands are dropped.
`ifndef CWP_MAP_VH
`define CWP_MAP_VH

// ==========================================================
// Command codes
`define CWP_CODE_TIER 8'hfa
`define CWP_CODE_PRIV 8'hfb
`define CWP_CODE_PUB 8'hfc
`define CWP_CODE_MASK 8'hfd

// ==========================================================
// Security levels
`define CWP_LVL_OPEN 2'h0
`define CWP_LVL_PUB 2'h1
`define CWP_LVL_USER 2'h2
`define CWP_LVL_VEND 2'h3

// ==========================================================
// Block lengths in bytes and widths in bits
`define CWP_LEN_PRIV 6'h09
`define CWP_LEN_PUB 6'h04
`define CWP_LEN_MASK 6'h20
`define CWP_LEN_MAX 6'h3f
`define CWP_PRIV_W 72
`define CWP_PUB_W 32
`define CWP_MASK_W 256

// ==========================================================
// Reset contents
`define CWP_MASK_RST {8{32'hffffffff}}
`define CWP_USER_KEY_RST 72'h55_53_45_52_4b_45_59_30_31
`define CWP_DFLT_KEY_RST 72'h44_46_4c_54_4b_45_59_30_31
`define CWP_PUB_KEY_RST 32'h50_55_42_31
`define CWP_BYTE_ZERO 8'h00
`define CWP_TIER_PAD 6'h00

`endif

// ---- rtl/cwp_grant.v ----
`timescale 1ns/1ns
`default_nettype none
`include "cwp_map.vh"

// Write-permission decode for one command code
module cwp_grant (
  input wire [7:0] code,
  input wire [1:0] level,
  input wire dflt_sel,
  input wire [`CWP_MASK_W-1:0] usr_mask,
  input wire [`CWP_MASK_W-1:0] dflt_mask,
  output reg allow
);

  reg usr_bit;
  reg dflt_bit;

  // ==========================================================
  // Decision
  always @* begin
    usr_bit = usr_mask[code]; // RL14 RL15
    dflt_bit = dflt_mask[code];
    allow = 1'b0;
    case (code)
      `CWP_CODE_TIER: allow = 1'b0; // RL1
      `CWP_CODE_PRIV: allow = 1'b1;
      `CWP_CODE_PUB: allow = 1'b1; // RL4
      `CWP_CODE_MASK: begin
        // Default mask needs vendor level, user mask needs user level
        if (dflt_sel) begin
          allow = (level >= `CWP_LVL_VEND); // RL17
        end else begin
          allow = (level >= `CWP_LVL_USER); // RL18
        end
      end
      default: begin
        if (!dflt_bit) begin
          allow = (level >= `CWP_LVL_VEND); // RL8 RL16
        end else if (!usr_bit) begin
          allow = (level >= `CWP_LVL_USER); // RL9 RL6
        end else begin
          allow = 1'b1;
        end
      end
    endcase
  end

endmodule

`default_nettype wire

// ---- rtl/cwp_top.v ----
`timescale 1ns/1ns
`default_nettype none
`include "cwp_map.vh"

// Command write protection: level, passwords and masks
module cwp_top #(
  parameter [`CWP_PUB_W-1:0] PUB_KEY = `CWP_PUB_KEY_RST,
  parameter [`CWP_PRIV_W-1:0] USER_KEY_RST = `CWP_USER_KEY_RST,
  parameter [`CWP_PRIV_W-1:0] DFLT_KEY_RST = `CWP_DFLT_KEY_RST,
  parameter [`CWP_MASK_W-1:0] MASK_RST = `CWP_MASK_RST
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire xfer_start,
  input wire [7:0] xfer_code,
  input wire xfer_write,
  input wire xfer_byte_valid,
  input wire [7:0] xfer_byte,
  input wire xfer_stop,
  input wire store_dflt,
  input wire rd_req,
  input wire [7:0] rd_code,
  input wire [4:0] rd_index,
  output reg rd_valid,
  output reg rd_hit,
  output reg [7:0] rd_data,
  output reg wr_allow_valid,
  output reg wr_allow,
  output reg key_accept,
  output reg wr_refused,
  output reg [7:0] access_tier
);

  // ==========================================================
  // Transaction states
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_COLLECT = 3'b010;
  localparam [2:0] S_APPLY = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [1:0] level;
  reg [1:0] next_level;
  reg [7:0] code_q;
  reg dflt_q;
  reg allow_q;
  reg [5:0] cnt;
  reg [`CWP_MASK_W-1:0] buf_q;
  reg [`CWP_MASK_W-1:0] usr_mask;
  reg [`CWP_MASK_W-1:0] dflt_mask;
  reg [`CWP_PRIV_W-1:0] usr_key;
  reg [`CWP_PRIV_W-1:0] dflt_key;
  reg [`CWP_PUB_W-1:0] pub_last;
  wire grant;

  // ==========================================================
  // Byte picker shared by every block readback
  function [7:0] pick_byte;
    input [`CWP_MASK_W-1:0] vec;
    input [4:0] idx;
    begin
      pick_byte = vec[{idx, 3'b000} +: 8]; // RL11 RL14
    end
  endfunction

  // Length check for a completed block write
  function len_ok;
    input [5:0] got;
    input [5:0] want;
    begin
      len_ok = (got == want);
    end
  endfunction

  // ==========================================================
  // Permission for the code being opened
  // Masks and level are read at the opening byte; a key raised later helps the next write
  cwp_grant u_grant (
    .code(xfer_code),
    .level(level),
    .dflt_sel(store_dflt),
    .usr_mask(usr_mask),
    .dflt_mask(dflt_mask),
    .allow(grant)
  );

  // ==========================================================
  // State sequencing
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (xfer_start && xfer_write) begin
          next_state = S_COLLECT;
        end
      end
      S_COLLECT: begin
        if (xfer_start && !xfer_write) begin
          next_state = S_IDLE;
        end else if (xfer_stop) begin
          next_state = S_APPLY;
        end
      end
      S_APPLY: begin
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Level update from received passwords
  // Levels only rise here; a mismatch or a short block leaves it alone
  always @* begin
    next_level = level;
    if (state == S_APPLY && allow_q) begin
      case (code_q)
        `CWP_CODE_PUB: begin
          if (len_ok(cnt, `CWP_LEN_PUB) && buf_q[`CWP_PUB_W-1:0] == PUB_KEY &&
              level < `CWP_LVL_PUB) begin
            next_level = `CWP_LVL_PUB; // RL19 RL12
          end
        end
        `CWP_CODE_PRIV: begin
          if (len_ok(cnt, `CWP_LEN_PRIV)) begin
            if (dflt_q && buf_q[`CWP_PRIV_W-1:0] == dflt_key &&
                level < `CWP_LVL_VEND) begin
              next_level = `CWP_LVL_VEND; // RL19 RL8
            end else if (!dflt_q && buf_q[`CWP_PRIV_W-1:0] == usr_key &&
                         level < `CWP_LVL_USER) begin
              next_level = `CWP_LVL_USER; // RL19 RL9
            end
          end
        end
        default: begin
          next_level = level; // RL20
        end
      endcase
    end
  end

  // ==========================================================
  // Control and level registers
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= S_IDLE;
      level <= `CWP_LVL_OPEN;
      code_q <= `CWP_BYTE_ZERO;
      dflt_q <= 1'b0;
      allow_q <= 1'b0;
      cnt <= 6'h00;
    end else begin
      state <= next_state;
      level <= next_level;
      // A start in the apply cycle is dropped rather than racing the store update
      if (xfer_start && xfer_write && state != S_APPLY) begin
        // Store choice and permission are frozen at the opening byte
        code_q <= xfer_code;
        dflt_q <= store_dflt;
        allow_q <= grant; // RL3
        cnt <= 6'h00;
      end else if (state == S_COLLECT && xfer_byte_valid && cnt != `CWP_LEN_MAX) begin
        cnt <= cnt + 6'h01;
      end
    end
  end

  // ==========================================================
  // Data collection, byte 0 lands in the low bits
  // Bytes past the longest block are counted but dropped
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      buf_q <= {`CWP_MASK_W{1'b0}};
    end else if (state == S_COLLECT && xfer_byte_valid && cnt < `CWP_LEN_MASK) begin
      buf_q[{cnt[4:0], 3'b000} +: 8] <= xfer_byte; // RL11
    end
  end

  // ==========================================================
  // Stores: masks, private keys and last public string
  // Only an exact block length lands; a short or long block changes nothing
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      usr_mask <= MASK_RST;
      dflt_mask <= MASK_RST;
      usr_key <= USER_KEY_RST;
      dflt_key <= DFLT_KEY_RST;
      pub_last <= {`CWP_PUB_W{1'b0}};
    end else if (state == S_APPLY && allow_q) begin
      case (code_q)
        `CWP_CODE_MASK: begin
          if (len_ok(cnt, `CWP_LEN_MASK)) begin
            if (dflt_q) begin
              dflt_mask <= buf_q; // RL13 RL17 RL7
            end else begin
              usr_mask <= buf_q; // RL13 RL18 RL7
            end
          end
        end
        `CWP_CODE_PRIV: begin
          // Already at or above the store's level: the block replaces the key
          if (len_ok(cnt, `CWP_LEN_PRIV)) begin
            if (dflt_q && level == `CWP_LVL_VEND) begin
              dflt_key <= buf_q[`CWP_PRIV_W-1:0]; // RL7
            end else if (!dflt_q && level >= `CWP_LVL_USER) begin
              usr_key <= buf_q[`CWP_PRIV_W-1:0]; // RL10
            end
          end
        end
        `CWP_CODE_PUB: begin
          if (len_ok(cnt, `CWP_LEN_PUB)) begin
            pub_last <= buf_q[`CWP_PUB_W-1:0]; // RL12
          end
        end
        default: begin
          pub_last <= pub_last;
        end
      endcase
    end
  end

  // ==========================================================
  // Write permission answer and outcome pulses
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_allow_valid <= 1'b0;
      wr_allow <= 1'b0;
      wr_refused <= 1'b0;
      key_accept <= 1'b0;
    end else begin
      wr_allow_valid <= xfer_start && xfer_write && state != S_APPLY;
      if (xfer_start && xfer_write && state != S_APPLY) begin
        wr_allow <= grant; // RL16 RL6
      end
      // Dropped write shows only as this pulse, nothing is stored
      // Key pulse and level mirror move on one edge so they can be paired
      wr_refused <= (state == S_APPLY) && !allow_q; // RL20
      key_accept <= (next_level != level); // RL19
    end
  end

  // ==========================================================
  // Readback, always answered whatever the protection
  // Keys read back in clear: the lock guards writes, never reads
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_valid <= 1'b0;
      rd_hit <= 1'b0;
      rd_data <= `CWP_BYTE_ZERO;
    end else begin
      rd_valid <= rd_req; // RL2
      if (rd_req) begin
        rd_hit <= 1'b1;
        case (rd_code)
          `CWP_CODE_TIER: begin
            rd_data <= (rd_index == 5'h00) ? {`CWP_TIER_PAD, level} : `CWP_BYTE_ZERO; // RL1
          end
          `CWP_CODE_PRIV: begin
            if ({1'b0, rd_index} < `CWP_LEN_PRIV) begin
              rd_data <= pick_byte({184'h0, store_dflt ? dflt_key : usr_key}, rd_index);
            end else begin
              rd_data <= `CWP_BYTE_ZERO; // RL10
            end
          end
          `CWP_CODE_PUB: begin
            if ({1'b0, rd_index} < `CWP_LEN_PUB) begin
              rd_data <= pick_byte({224'h0, pub_last}, rd_index);
            end else begin
              rd_data <= `CWP_BYTE_ZERO;
            end
          end
          `CWP_CODE_MASK: begin
            rd_data <= pick_byte(store_dflt ? dflt_mask : usr_mask, rd_index); // RL13
          end
          default: begin
            // Other codes belong to the rest of the register file
            rd_hit <= 1'b0;
            rd_data <= `CWP_BYTE_ZERO;
          end
        endcase
      end else begin
        rd_hit <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Level mirror for status logic
  // Fed from next_level so the new tier is not a cycle behind key_accept
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      access_tier <= `CWP_BYTE_ZERO;
    end else begin
      access_tier <= {`CWP_TIER_PAD, next_level}; // RL1
    end
  end

endmodule

`default_nettype wire

// ---- test/cwp_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========
// Port checks for the write-protection block
module cwp_props (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic xfer_start,
  input wire logic [7:0] xfer_code,
  input wire logic xfer_write,
  input wire logic rd_req,
  input wire logic [7:0] rd_code,
  input wire logic rd_valid,
  input wire logic rd_hit,
  input wire logic [7:0] rd_data,
  input wire logic wr_allow_valid,
  input wire logic wr_allow,
  input wire logic key_accept,
  input wire logic [7:0] access_tier
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Write opening, and one aimed at the read-only level byte
  sequence s_open;
    xfer_start && xfer_write;
  endsequence
  sequence s_tier_wr;
    s_open ##0 (xfer_code == 8'hfa);
  endsequence
  a_read_answered: assert property (rd_req |=> rd_valid)
    else $error("read not answered");
  a_no_stray_read: assert property (!rd_req |=> !rd_valid)
    else $error("read answer without request");
  a_hit_decode: assert property (rd_req |=>
    rd_hit == ($past(rd_code) inside {[8'hfa:8'hfd]}))
    else $error("read hit decode wrong");
  a_miss_zero: assert property (rd_valid && !rd_hit |-> rd_data == 8'h00)
    else $error("unknown code read not zero");
  a_tier_range: assert property (access_tier <= 8'h03)
    else $error("level encoding out of range");
  // Level may only move up, and only with an accepted key
  a_tier_rise: assert property (access_tier != $past(access_tier) |->
    key_accept && access_tier > $past(access_tier))
    else $error("level moved without key");
  a_key_moves: assert property (key_accept |-> access_tier != $past(access_tier))
    else $error("key accepted but level kept");
  a_allow_timing: assert property (s_open |=> wr_allow_valid)
    else $error("write permission late");
  a_tier_locked: assert property (s_tier_wr |=> !wr_allow)
    else $error("level byte writable");
endmodule

bind cwp_top cwp_props u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .xfer_start(xfer_start), .xfer_code(xfer_code), .xfer_write(xfer_write),
  .rd_req(rd_req), .rd_code(rd_code), .rd_valid(rd_valid), .rd_hit(rd_hit),
  .rd_data(rd_data), .wr_allow_valid(wr_allow_valid), .wr_allow(wr_allow),
  .key_accept(key_accept), .access_tier(access_tier));
`default_nettype wire

// ---- test/cwp_host.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========
// Management host: block writes and byte reads
module cwp_host (
  input wire logic ref_clk,
  output logic xfer_start,
  output logic [7:0] xfer_code,
  output logic xfer_write,
  output logic xfer_byte_valid,
  output logic [7:0] xfer_byte,
  output logic xfer_stop,
  output logic store_dflt,
  output logic rd_req,
  output logic [7:0] rd_code,
  output logic [4:0] rd_index
);
  initial begin
    {xfer_start, xfer_code, xfer_write, xfer_byte_valid, xfer_byte} = '0;
    {xfer_stop, store_dflt, rd_req, rd_code, rd_index} = '0;
  end
  // Start, n bytes low first, stop, then sit out the apply cycle
  task automatic send(input logic [7:0] c, input int n, input logic [255:0] d,
    input logic s);
    @(posedge ref_clk) #1;
    xfer_start = 1;
    xfer_code = c;
    xfer_write = 1;
    store_dflt = s;
    @(posedge ref_clk) #1;
    xfer_start = 0;
    for (int i = 0; i < n; i++) begin
      xfer_byte_valid = 1;
      xfer_byte = d[8*i +: 8];
      @(posedge ref_clk) #1;
    end
    xfer_byte_valid = 0;
    xfer_byte = ~xfer_byte; // Idle byte lane never shows a stale value
    xfer_stop = 1;
    @(posedge ref_clk) #1;
    xfer_stop = 0;
    repeat (2) @(posedge ref_clk);
  endtask
  // One-cycle read request
  task automatic fetch(input logic [7:0] c, input logic [4:0] i, input logic s);
    @(posedge ref_clk) #1;
    rd_req = 1;
    rd_code = c;
    rd_index = i;
    store_dflt = s;
    @(posedge ref_clk) #1;
    rd_req = 0;
  endtask
endmodule
`default_nettype wire

// ---- test/command_write_protection_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cwp_map.vh"
// ==========
// Bench: host drives, monitor scores against queued notes
module command_write_protection_test;
  logic ref_clk = 0;
  logic sys_rst = 1;
  wire xs, xw, xv, xp, sd, rq_v, rv, rh, wv, wa, ka, wrf;
  wire [7:0] xc, xb, rc, rdat, tier;
  wire [4:0] ri;
  logic [8:0] rq[$];
  logic aq[$];
  logic fq[$];
  logic [7:0] kq[$];
  int miscompares = 0;
  int check_count = 0;
  int seed = 32'h3b7bbd34;
  always #4 ref_clk = ~ref_clk;
  cwp_host host (.ref_clk(ref_clk), .xfer_start(xs), .xfer_code(xc), .xfer_write(xw),
    .xfer_byte_valid(xv), .xfer_byte(xb), .xfer_stop(xp), .store_dflt(sd),
    .rd_req(rq_v), .rd_code(rc), .rd_index(ri));
  // Code 0x21 starts locked in both stores
  cwp_top #(.MASK_RST(~(256'h1 << 8'h21))) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .xfer_start(xs), .xfer_code(xc), .xfer_write(xw), .xfer_byte_valid(xv),
    .xfer_byte(xb), .xfer_stop(xp), .store_dflt(sd), .rd_req(rq_v), .rd_code(rc),
    .rd_index(ri), .rd_valid(rv), .rd_hit(rh), .rd_data(rdat), .wr_allow_valid(wv),
    .wr_allow(wa), .key_accept(ka), .wr_refused(wrf), .access_tier(tier));
  task automatic cmp_rd(input logic [8:0] g, input logic [8:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_wr(input logic g, input logic e);
    cmp_rd({8'h00, g}, {8'h00, e});
  endtask
  task automatic cmp_ref(input logic g, input logic e);
    cmp_rd({8'h00, g}, {8'h00, e});
  endtask
  task automatic cmp_key(input logic [7:0] g, input logic [7:0] e);
    cmp_rd({1'b0, g}, {1'b0, e});
  endtask
  task automatic expect_tier(input logic [7:0] t);
    kq.push_back(t);
  endtask
  // Negedge sampling: registered pulses are settled by then
  always @(negedge ref_clk) begin
    if (rv === 1'b1) cmp_rd({rh, rdat}, rq.size() ? rq.pop_front() : 9'hxxx);
    if (wv === 1'b1) cmp_wr(wa, aq.size() ? aq.pop_front() : 1'bx);
    if (wrf === 1'b1) cmp_ref(wrf, fq.size() ? fq.pop_front() : 1'bx);
    if (ka === 1'b1) cmp_key(tier, kq.size() ? kq.pop_front() : 8'hxx);
  end
  task automatic wr(input logic [7:0] c, input int n, input logic [255:0] d,
    input logic s, input logic a);
    aq.push_back(a);
    if (!a) fq.push_back(1'b1);
    host.send(c, n, d, s);
  endtask
  task automatic rd(input logic [7:0] c, input logic [4:0] i, input logic s,
    input logic [8:0] e);
    rq.push_back(e);
    host.fetch(c, i, s);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end
  initial begin
    logic [255:0] m, m2;
    logic [4:0] k;
    for (int i = 0; i < 8; i++) m[32*i +: 32] = $random(seed);
    for (int i = 0; i < 8; i++) m2[32*i +: 32] = $random(seed);
    m[8'h22] = 1'b0;
    k = $random(seed);
    repeat (5) @(posedge ref_clk);
    #1 sys_rst = 0;
    rd(8'hfa, 0, 0, 9'h100);
    rd(8'hfd, 4, 0, 9'h1fd);
    rd(8'hfd, 31, 1, 9'h1ff);
    rd(8'h10, 0, 0, 9'h000);
    wr(8'h21, 1, 0, 0, 0);
    wr(8'h22, 1, 0, 0, 1);
    wr(8'hfc, 4, $random(seed), 0, 1);
    rd(8'hfa, 0, 0, 9'h100);
    expect_tier(8'h01);
    wr(8'hfc, 4, `CWP_PUB_KEY_RST, 0, 1);
    rd(8'hfa, 0, 0, 9'h101);
    rd(8'hfc, 0, 0, 9'h131);
    wr(8'hfd, 32, m, 0, 0);
    wr(8'hfb, 8, `CWP_USER_KEY_RST, 0, 1);
    rd(8'hfa, 0, 0, 9'h101);
    expect_tier(8'h02);
    wr(8'hfb, 9, `CWP_USER_KEY_RST, 0, 1);
    rd(8'hfa, 0, 0, 9'h102);
    wr(8'hfd, 32, m, 0, 1);
    rd(8'hfd, k, 0, {1'b1, m[8*k +: 8]});
    wr(8'h22, 1, 0, 0, 1);
    wr(8'h21, 1, 0, 0, 0);
    wr(8'hfd, 32, m2, 1, 0);
    expect_tier(8'h03);
    wr(8'hfb, 9, `CWP_DFLT_KEY_RST, 1, 1);
    rd(8'hfa, 0, 0, 9'h103);
    wr(8'h21, 1, 0, 0, 1);
    wr(8'hfd, 32, m2, 1, 1);
    rd(8'hfd, k, 1, {1'b1, m2[8*k +: 8]});
    rd(8'hfd, k, 0, {1'b1, m[8*k +: 8]});
    wr(8'hfa, 1, 8'h00, 0, 0);
    rd(8'hfa, 0, 0, 9'h103);
    @(posedge ref_clk) #1 sys_rst = 1;
    @(posedge ref_clk) #1 sys_rst = 0;
    rd(8'hfa, 0, 0, 9'h100);
    repeat (4) @(posedge ref_clk);
    if (rq.size() != 0 || aq.size() != 0) miscompares++;
    if (fq.size() != 0 || kq.size() != 0) miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
